/* File: lld_channel.v */
// linked-list dma channel: register slave, packet fetch, transfer and stop/halt/error control
// Operation
// [RULE1] software loads first packet address into pointer
// [RULE2] software zeroes byte count before fresh run
// [RULE3] software clears status, then sets go
// [RULE4] packet port chosen apart from transfer ports
// [RULE5] walk chain to last packet, then done
// [RULE6] nonzero count at start: drain first, then list
// [RULE7] stop: no source requests, stop after destination
// [RULE8] resume stop: clear status, then go
// [RULE9] halt: finish current packet, set halt
// [RULE10] resume halt: clear halt with chain, go
// [RULE11] six status sources, each with enable
// [RULE12] separate error bits per port
// [RULE13] pci aborts or retry limit set error
// [RULE14] transfer error ack or retry sets error
// [RULE15] parity errors never touch channel state
// [RULE16] source error: flush buffered data, flag error
// [RULE17] destination error: drop buffered data, flag
// [RULE18] packet fetch error: registers stay untouched
// [RULE19] packet words at 04, 0c, 14, 1c
// [RULE20] pci packets little-endian, processor bus big
// [RULE21] interrupt when enabled status bit set
`timescale 1ns/100ps
`include "lld_regs.vh"
module lld_channel (
  input wire clock,
  input wire rst_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [3:0] avs_byteenable,
  output reg [31:0] avs_readdata,
  output reg avs_waitrequest,
  output reg mreq_valid,
  input wire mreq_ready,
  output reg [1:0] mreq_port,
  output reg mreq_write,
  output reg [31:0] mreq_addr,
  output reg [31:0] mreq_wdata,
  input wire mresp_valid,
  input wire [1:0] mresp_err, // no parity code: parity errors never reach the channel [RULE15]
  input wire [31:0] mresp_rdata,
  output reg irq
);
  localparam S_IDLE = 3'h0;
  localparam S_NEXT = 3'h1;
  localparam S_FETCH_WAIT = 3'h2;
  localparam S_COMMIT = 3'h3;
  localparam S_SRC_WAIT = 3'h4;
  localparam S_DST_WAIT = 3'h5;

  reg [2:0] state;
  reg [31:0] src_addr;
  reg [31:0] dst_addr;
  reg [23:0] byte_count;
  reg [1:0] src_port;
  reg [1:0] dst_port;
  reg [31:5] next_packet_pointer;
  reg last_flag;
  reg [1:0] fetch_port;
  reg chain;
  reg [5:0] irq_enable;
  reg active;
  reg stop_pend;
  reg halt_pend;
  reg pkt_ran;
  reg [1:0] fetch_idx;
  reg [31:0] held_word;
  reg [5:0] stat_set;
  wire [5:0] status;
  wire [127:0] pkt_words;

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] be;
    begin
      merge = {be[3] ? nw[31:24] : old[31:24], be[2] ? nw[23:16] : old[23:16],
               be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
    end
  endfunction

  // pci ports flag any abort or retry limit, the processor bus only tea or retry
  function is_err;
    input [1:0] port;
    input [1:0] code;
    begin
      if (port == `LLD_PORT_PB)
        is_err = (code == `LLD_ERR_MABORT_TEA) || (code == `LLD_ERR_RETRY); // [RULE14]
      else
        is_err = (code != `LLD_ERR_NONE); // [RULE13]
    end
  endfunction

  function [5:0] err_bit;
    input [1:0] port;
    begin
      err_bit = 6'h00;
      if (port != 2'h3)
        err_bit[port + 2'h1] = 1'b1; // [RULE12]
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // register slave

  wire wr_fire = avs_write && !avs_waitrequest;
  wire [31:0] tcr_word = {4'h0, dst_port, src_port, byte_count};
  wire [31:0] cpp_word = {next_packet_pointer, 4'h0, last_flag};
  wire [31:0] gcsr_word = {10'h000, irq_enable, 2'h0, status, 4'h0,
                           halt_pend, stop_pend, chain, active};
  wire gcsr_wr = wr_fire && avs_address == `LLD_OFF_GCSR;
  wire [31:0] gcsr_new = merge(gcsr_word, avs_writedata, avs_byteenable);
  wire [31:0] tcr_new = merge(tcr_word, avs_writedata, avs_byteenable);
  wire [31:0] cpp_new = merge(cpp_word, avs_writedata, avs_byteenable);
  wire [5:0] stat_clear = gcsr_wr ? (avs_writedata[13:8] & {6{avs_byteenable[1]}}) : 6'h00;
  // go is refused while a status bit would remain set after this write [RULE3] [RULE8]
  wire go_ok = gcsr_wr && avs_byteenable[0] && avs_writedata[`LLD_GCSR_GO] && !active &&
               ((status & ~stat_clear) == 6'h00) && (stat_set == 6'h00);
  wire cfg_wr = wr_fire && !active;

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata <= `LLD_RST_WORD;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (avs_read || avs_write) begin
      avs_waitrequest <= 1'b0;
      case (avs_address)
        `LLD_OFF_SRC: avs_readdata <= src_addr;
        `LLD_OFF_DST: avs_readdata <= dst_addr;
        `LLD_OFF_TCR: avs_readdata <= tcr_word;
        `LLD_OFF_CPP: avs_readdata <= cpp_word;
        `LLD_OFF_ATTR: avs_readdata <= {30'h00000000, fetch_port};
        `LLD_OFF_GCSR: avs_readdata <= gcsr_word;
        default: avs_readdata <= `LLD_RST_WORD;
      endcase
    end
  end

  lld_sticky #(
    .WIDTH(`LLD_NUM_STAT)
  ) u_status (
    .clock(clock),
    .rst_n(rst_n),
    .set(stat_set),
    .clear(stat_clear),
    .status(status)
  ); // [RULE11]

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(status & irq_enable); // [RULE21]
  end

  lld_pkt_load u_pkt (
    .clock(clock),
    .rst_n(rst_n),
    .word_valid(state == S_FETCH_WAIT && mresp_valid && !is_err(fetch_port, mresp_err)),
    .word_idx(fetch_idx),
    .word_data(mresp_rdata),
    .big_endian(fetch_port == `LLD_PORT_PB),
    .words(pkt_words)
  );

  ////////////////////////////////////////////////////////////////////////////
  // channel sequencer

  wire [23:0] step = (byte_count < `LLD_WORD_BYTES) ? byte_count : `LLD_WORD_BYTES;
  // first word of a packet; later words step from the previous request address
  wire [31:0] fetch_addr = {next_packet_pointer, `LLD_PKT_SRC_OFF};

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_IDLE;
      src_addr <= `LLD_RST_WORD;
      dst_addr <= `LLD_RST_WORD;
      byte_count <= 24'h000000;
      src_port <= `LLD_PORT_PCI1;
      dst_port <= `LLD_PORT_PCI1;
      next_packet_pointer <= 27'h0;
      last_flag <= 1'b0;
      fetch_port <= `LLD_PORT_PCI1;
      chain <= 1'b0;
      irq_enable <= 6'h00;
      active <= 1'b0;
      stop_pend <= 1'b0;
      halt_pend <= 1'b0;
      pkt_ran <= 1'b0;
      fetch_idx <= 2'h0;
      held_word <= `LLD_RST_WORD;
      stat_set <= 6'h00;
      mreq_valid <= 1'b0;
      mreq_port <= `LLD_PORT_PCI1;
      mreq_write <= 1'b0;
      mreq_addr <= `LLD_RST_WORD;
      mreq_wdata <= `LLD_RST_WORD;
    end else begin
      stat_set <= 6'h00;
      // address, count and pointer registers ignore writes while the channel runs
      if (cfg_wr && avs_address == `LLD_OFF_SRC)
        src_addr <= merge(src_addr, avs_writedata, avs_byteenable);
      if (cfg_wr && avs_address == `LLD_OFF_DST)
        dst_addr <= merge(dst_addr, avs_writedata, avs_byteenable);
      if (cfg_wr && avs_address == `LLD_OFF_TCR)
        {dst_port, src_port, byte_count} <= tcr_new[27:0];
      if (cfg_wr && avs_address == `LLD_OFF_CPP) begin
        next_packet_pointer <= cpp_new[31:5]; // [RULE1]
        last_flag <= cpp_new[`LLD_CPP_LAST];
      end
      if (cfg_wr && avs_address == `LLD_OFF_ATTR && avs_byteenable[0])
        fetch_port <= avs_writedata[1:0]; // [RULE4]
      if (gcsr_wr) begin
        irq_enable <= gcsr_new[21:16];
        if (!active)
          chain <= gcsr_new[`LLD_GCSR_CHAIN]; // [RULE10]
        if (active && avs_byteenable[0] && avs_writedata[`LLD_GCSR_STOP_REQ])
          stop_pend <= 1'b1;
        if (active && avs_byteenable[0] && avs_writedata[`LLD_GCSR_HALT_REQ])
          halt_pend <= 1'b1;
      end
      if (mreq_valid && mreq_ready)
        mreq_valid <= 1'b0;
      case (state)
        S_IDLE: begin
          // requests left over from a finished run die here, one clear for every exit
          stop_pend <= 1'b0;
          halt_pend <= 1'b0;
          if (go_ok) begin
            active <= 1'b1;
            pkt_ran <= 1'b0;
            state <= S_NEXT;
          end
        end
        S_NEXT: begin
          if (byte_count != 24'h000000) begin
            if (stop_pend) begin
              stat_set[`LLD_ST_STOP] <= 1'b1; // [RULE7]
              active <= 1'b0;
              state <= S_IDLE;
            end else begin
              // a leftover count is drained as a direct transfer before the list [RULE6]
              mreq_valid <= 1'b1;
              mreq_port <= src_port;
              mreq_write <= 1'b0;
              mreq_addr <= src_addr;
              state <= S_SRC_WAIT;
            end
          end else if (chain && (!pkt_ran || !last_flag)) begin
            if (halt_pend && pkt_ran) begin
              stat_set[`LLD_ST_HALT] <= 1'b1; // [RULE9]
              active <= 1'b0;
              state <= S_IDLE;
            end else if (stop_pend) begin
              stat_set[`LLD_ST_STOP] <= 1'b1; // [RULE7]
              active <= 1'b0;
              state <= S_IDLE;
            end else begin
              fetch_idx <= 2'h0;
              mreq_valid <= 1'b1;
              mreq_port <= fetch_port; // [RULE4]
              mreq_write <= 1'b0;
              mreq_addr <= fetch_addr; // [RULE19]
              state <= S_FETCH_WAIT;
            end
          end else begin
            stat_set[`LLD_ST_DONE] <= 1'b1; // [RULE5]
            active <= 1'b0;
            state <= S_IDLE;
          end
        end
        S_FETCH_WAIT: begin
          if (mresp_valid) begin
            if (is_err(fetch_port, mresp_err)) begin
              // the partly fetched packet is thrown away [RULE18]
              stat_set <= err_bit(fetch_port);
              active <= 1'b0;
              state <= S_IDLE;
            end else if (fetch_idx == 2'h3) begin
              state <= S_COMMIT;
            end else begin
              fetch_idx <= fetch_idx + 2'h1;
              mreq_valid <= 1'b1;
              mreq_addr <= mreq_addr + 32'h00000008; // [RULE19]
            end
          end
        end
        S_COMMIT: begin
          src_addr <= pkt_words[31:0];
          dst_addr <= pkt_words[63:32];
          {dst_port, src_port, byte_count} <= pkt_words[91:64];
          next_packet_pointer <= pkt_words[127:101];
          last_flag <= pkt_words[96 + `LLD_CPP_LAST];
          pkt_ran <= 1'b1;
          state <= S_NEXT;
        end
        S_SRC_WAIT: begin
          if (mresp_valid) begin
            if (is_err(src_port, mresp_err)) begin
              // one word in flight: earlier words already reached the destination [RULE16]
              stat_set <= err_bit(src_port);
              active <= 1'b0;
              state <= S_IDLE;
            end else begin
              held_word <= mresp_rdata;
              mreq_valid <= 1'b1;
              mreq_port <= dst_port;
              mreq_write <= 1'b1;
              mreq_addr <= dst_addr;
              mreq_wdata <= mresp_rdata;
              state <= S_DST_WAIT;
            end
          end
        end
        S_DST_WAIT: begin
          if (mresp_valid) begin
            if (is_err(dst_port, mresp_err)) begin
              held_word <= `LLD_RST_WORD; // [RULE17]
              stat_set <= err_bit(dst_port);
              active <= 1'b0;
              state <= S_IDLE;
            end else begin
              // stop is judged only after the destination write has completed [RULE7]
              byte_count <= byte_count - step;
              src_addr <= src_addr + 32'h00000004;
              dst_addr <= dst_addr + 32'h00000004;
              state <= S_NEXT;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule

/* File: lld_regs.vh */
// register offsets, field positions, reset values and codes of the linked-list channel
`ifndef LLD_REGS_VH
`define LLD_REGS_VH
`define LLD_OFF_SRC 8'h00
`define LLD_OFF_DST 8'h04
`define LLD_OFF_TCR 8'h08
`define LLD_OFF_CPP 8'h0c
`define LLD_OFF_ATTR 8'h10
`define LLD_OFF_GCSR 8'h14
`define LLD_TCR_BC_HI 23
`define LLD_TCR_SRC_LO 24
`define LLD_TCR_DST_LO 26
`define LLD_CPP_NCP_LO 5
`define LLD_CPP_LAST 0
`define LLD_GCSR_GO 0
`define LLD_GCSR_CHAIN 1
`define LLD_GCSR_STOP_REQ 2
`define LLD_GCSR_HALT_REQ 3
`define LLD_GCSR_STAT_LO 8
`define LLD_GCSR_EN_LO 16
`define LLD_ST_DONE 0
`define LLD_ST_HALT 4
`define LLD_ST_STOP 5
`define LLD_NUM_STAT 6
`define LLD_PORT_PCI1 2'h0
`define LLD_PORT_PCI2 2'h1
`define LLD_PORT_PB 2'h2
`define LLD_ERR_NONE 2'h0
`define LLD_ERR_MABORT_TEA 2'h1
`define LLD_ERR_TABORT 2'h2
`define LLD_ERR_RETRY 2'h3
`define LLD_PKT_SRC_OFF 5'h04
`define LLD_WORD_BYTES 24'h000004
`define LLD_RST_WORD 32'h00000000
`endif

/* File: lld_sticky.v */
// sticky status bits: hardware sets, software writes one to clear, set wins
`timescale 1ns/100ps
module lld_sticky #(
  parameter WIDTH = 6
) (
  input wire clock,
  input wire rst_n,
  input wire [WIDTH-1:0] set,
  input wire [WIDTH-1:0] clear,
  output wire [WIDTH-1:0] status
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg bit_q;
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n)
          bit_q <= 1'b0;
        else if (set[i])
          bit_q <= 1'b1;
        else if (clear[i])
          bit_q <= 1'b0;
      end
      assign status[i] = bit_q;
    end
  endgenerate
endmodule

/* File: lld_pkt_load.v */
// holds the four words of a command packet as they are fetched
`timescale 1ns/100ps
module lld_pkt_load (
  input wire clock,
  input wire rst_n,
  input wire word_valid,
  input wire [1:0] word_idx,
  input wire [31:0] word_data,
  input wire big_endian,
  output wire [127:0] words
);
  // processor bus memory holds packets big-endian, pci memory little-endian [RULE20]
  wire [31:0] swapped = big_endian ?
    {word_data[7:0], word_data[15:8], word_data[23:16], word_data[31:24]} : word_data;
  genvar i;
  generate
    for (i = 0; i < 4; i = i + 1) begin : g_word
      localparam [1:0] IDX = i;
      reg [31:0] word_q;
      always @(posedge clock or negedge rst_n) begin
        if (!rst_n)
          word_q <= `LLD_RST_WORD;
        else if (word_valid && word_idx == IDX)
          word_q <= swapped;
      end
      assign words[32*i+31:32*i] = word_q;
    end
  endgenerate
endmodule

/* File: lld_channel_props.sv */
// concurrent checks on the register bus and port-master link of the channel
`timescale 1ns/100ps
module lld_props (
  input wire clock,
  input wire rst_n,
  input wire [7:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire mreq_valid,
  input wire mreq_ready,
  input wire [1:0] mreq_port,
  input wire mreq_write,
  input wire [31:0] mreq_addr,
  input wire [31:0] mreq_wdata,
  input wire mresp_valid
);
  reg outstanding;
  ////////////////////////////////////////////////////////////
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      outstanding <= 1'b0;
    end else if (mreq_valid && mreq_ready) begin
      outstanding <= 1'b1;
    end else if (mresp_valid) begin
      outstanding <= 1'b0;
    end
  end
  default clocking dcb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  AST_WAIT_ANS: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered next cycle");
  AST_WAIT_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  AST_RD_STABLE: assert property (avs_waitrequest && $past(avs_waitrequest) |-> $stable(avs_readdata))
    else $error("read data moved outside a read");
  AST_UNMAPPED: assert property (avs_read && !avs_waitrequest && avs_address > 8'h14
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  AST_REQ_HOLD: assert property (mreq_valid && !mreq_ready
    |=> mreq_valid && $stable({mreq_port, mreq_write, mreq_addr, mreq_wdata}))
    else $error("port request changed before taken");
  AST_REQ_DROP: assert property (mreq_valid && mreq_ready |=> !mreq_valid)
    else $error("port request held after taken");
  AST_ONE_OUT: assert property (outstanding |-> !mreq_valid)
    else $error("second port request while one outstanding");
  // a read already decided at the stop edge may still rise once, hence the two-cycle lead
  AST_STOP_SRC: assert property (avs_write && !avs_waitrequest && avs_address == 8'h14 && avs_writedata[2]
    |-> ##2 (!($rose(mreq_valid) && !mreq_write))[*8]) else $error("source read after stop");
endmodule
bind lld_channel lld_props chk (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mreq_valid(mreq_valid),
  .mreq_ready(mreq_ready), .mreq_port(mreq_port), .mreq_write(mreq_write),
  .mreq_addr(mreq_addr), .mreq_wdata(mreq_wdata), .mresp_valid(mresp_valid));

/* File: lld_mem.sv */
// far-side model: memory targets on both pci ports and the processor bus
`timescale 1ns/100ps
module lld_mem (
  input wire clock,
  input wire rst_n,
  input wire mreq_valid,
  output wire mreq_ready,
  input wire [1:0] mreq_port,
  input wire mreq_write,
  input wire [31:0] mreq_addr,
  input wire [31:0] mreq_wdata,
  output reg mresp_valid,
  output reg [1:0] mresp_err,
  output reg [31:0] mresp_rdata,
  input wire slow,
  input wire [1:0] fault_port,
  input wire [1:0] fault_code
);
  // 64 words per port, indexed {port, addr[7:2]}; packets and data share it
  reg [31:0] mem [0:255];
  reg busy;
  reg [2:0] wait_cnt;
  reg [7:0] idx;
  reg wr;
  reg [31:0] wd;
  reg [1:0] code;
  ////////////////////////////////////////////////////////////
  assign mreq_ready = !busy;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      wait_cnt <= 3'd0;
      mresp_valid <= 1'b0;
      mresp_err <= 2'h0;
      mresp_rdata <= 32'h0;
    end else begin
      mresp_valid <= 1'b0;
      // released data lines toggle so a stale word is never mistaken for an answer
      mresp_rdata <= ~mresp_rdata;
      if (mreq_valid && !busy) begin
        busy <= 1'b1;
        wait_cnt <= slow ? 3'd5 : 3'd0;
        idx <= {mreq_port, mreq_addr[7:2]};
        wr <= mreq_write;
        wd <= mreq_wdata;
        code <= (mreq_port == fault_port) ? fault_code : 2'h0;
      end else if (busy && wait_cnt != 3'd0) begin
        wait_cnt <= wait_cnt - 3'd1;
      end else if (busy) begin
        busy <= 1'b0;
        mresp_valid <= 1'b1;
        mresp_err <= code;
        if (!wr) begin
          mresp_rdata <= mem[idx];
        end else if (code == 2'h0) begin
          mem[idx] <= wd;
        end
      end
    end
  end
endmodule

/* File: tb_top.sv */
// self-checking bench: chain, drain, stop, halt and error runs against the port model
`timescale 1ns/100ps
`include "lld_regs.vh"
`define CHK(a, b) begin n_tests = n_tests + 1; if ((a) !== (b)) begin \
  mismatches = mismatches + 1; $display("ERROR %0t got %h want %h", $time, (a), (b)); end end
module tb_top;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] avs_address = 8'h00;
  reg avs_read = 1'b0;
  reg avs_write = 1'b0;
  reg [31:0] avs_writedata = 32'h0;
  reg slow = 1'b0;
  reg [1:0] fault_port = 2'h0;
  reg [1:0] fault_code = 2'h0;
  wire [31:0] avs_readdata;
  wire avs_waitrequest;
  wire mreq_valid;
  wire mreq_ready;
  wire mreq_write;
  wire mresp_valid;
  wire irq;
  wire [1:0] mreq_port;
  wire [1:0] mresp_err;
  wire [31:0] mreq_addr;
  wire [31:0] mreq_wdata;
  wire [31:0] mresp_rdata;
  integer mismatches = 0;
  integer n_tests = 0;
  integer cycles = 0;
  integer p;
  integer c;
  reg [31:0] d;
  lld_channel uut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .mreq_valid(mreq_valid),
    .mreq_ready(mreq_ready), .mreq_port(mreq_port), .mreq_write(mreq_write),
    .mreq_addr(mreq_addr), .mreq_wdata(mreq_wdata), .mresp_valid(mresp_valid),
    .mresp_err(mresp_err), .mresp_rdata(mresp_rdata), .irq(irq));
  lld_mem far (.clock(clock), .rst_n(rst_n), .mreq_valid(mreq_valid), .mreq_ready(mreq_ready),
    .mreq_port(mreq_port), .mreq_write(mreq_write), .mreq_addr(mreq_addr),
    .mreq_wdata(mreq_wdata), .mresp_valid(mresp_valid), .mresp_err(mresp_err),
    .mresp_rdata(mresp_rdata), .slow(slow), .fault_port(fault_port), .fault_code(fault_code));
  initial begin
    forever #10 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////
  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches = mismatches + 1;
      end_sim;
    end
  end
  // one avalon transfer; held until waitrequest is sampled low, no cycle count assumed
  task bus(input [7:0] a, input w, input [31:0] v);
    begin
      avs_address <= a;
      avs_writedata <= v;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0) @(posedge clock);
      d = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge clock);
    end
  endtask
  task wait_idle;
    begin
      bus(`LLD_OFF_GCSR, 1'b0, 32'h0);
      while (d[`LLD_GCSR_GO] !== 1'b0) bus(`LLD_OFF_GCSR, 1'b0, 32'h0);
      bus(`LLD_OFF_GCSR, 1'b0, 32'h0);
    end
  endtask
  function [31:0] sw(input [31:0] w, input be);
    sw = be ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction
  task pkt(input [1:0] pt, input [7:0] b, input [31:0] s, input [31:0] t, input [63:0] n);
    begin
      far.mem[pt * 64 + b / 4 + 1] = sw(s, pt == 2'h2);
      far.mem[pt * 64 + b / 4 + 3] = sw(t, pt == 2'h2);
      far.mem[pt * 64 + b / 4 + 5] = sw(n[63:32], pt == 2'h2);
      far.mem[pt * 64 + b / 4 + 7] = sw(n[31:0], pt == 2'h2);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    for (c = 0; c < 64; c = c + 1) far.mem[64 + c] = 32'hc0de0000 + c;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    bus(`LLD_OFF_GCSR, 1'b0, 32'h0);
    `CHK(d, 32'h0);
    bus(8'h40, 1'b0, 32'h0);
    `CHK(d, 32'h0);
    // drain of 4 bytes, then two pci packets: 8 bytes and 4 bytes into the processor bus
    pkt(2'h0, 8'h40, 32'h00, 32'h80, {4'h0, 2'h2, 2'h1, 24'd8, 32'h60});
    pkt(2'h0, 8'h60, 32'h08, 32'h90, {4'h0, 2'h2, 2'h1, 24'd4, 32'h1});
    bus(`LLD_OFF_SRC, 1'b1, 32'h10);
    bus(`LLD_OFF_DST, 1'b1, 32'h00);
    bus(`LLD_OFF_TCR, 1'b1, {4'h0, 2'h0, 2'h1, 24'd4});
    bus(`LLD_OFF_ATTR, 1'b1, 32'h0);
    bus(`LLD_OFF_CPP, 1'b1, 32'h40);
    bus(`LLD_OFF_GCSR, 1'b1, 32'h00010003);
    wait_idle;
    `CHK(d[13:8], 6'h01);
    `CHK(irq, 1'b1);
    `CHK(far.mem[0], 32'hc0de0004);
    `CHK(far.mem[161], 32'hc0de0001);
    `CHK(far.mem[164], 32'hc0de0002);
    bus(`LLD_OFF_GCSR, 1'b1, 32'h00013f00);
    @(posedge clock);
    `CHK(irq, 1'b0);
    // one big-endian packet on the processor bus, pci ports for data
    pkt(2'h2, 8'h00, 32'h20, 32'h40, {4'h0, 2'h0, 2'h1, 24'd4, 32'h1});
    bus(`LLD_OFF_ATTR, 1'b1, 32'h2);
    bus(`LLD_OFF_TCR, 1'b0, 32'h0);
    `CHK(d[23:0], 24'd0);
    bus(`LLD_OFF_CPP, 1'b1, 32'h0);
    bus(`LLD_OFF_GCSR, 1'b1, 32'h3);
    wait_idle;
    `CHK(d[13:8], 6'h01);
    `CHK(far.mem[16], 32'hc0de0008);
    bus(`LLD_OFF_GCSR, 1'b1, 32'h3f00);
    // halt during the first packet, then resume at the stored pointer
    slow <= 1'b1;
    far.mem[164] = 32'h0;
    bus(`LLD_OFF_ATTR, 1'b1, 32'h0);
    bus(`LLD_OFF_CPP, 1'b1, 32'h40);
    bus(`LLD_OFF_GCSR, 1'b1, 32'h3);
    bus(`LLD_OFF_GCSR, 1'b1, 32'h8);
    wait_idle;
    `CHK(d[13:8], 6'h10);
    `CHK(far.mem[161], 32'hc0de0001);
    `CHK(far.mem[164], 32'h0);
    bus(`LLD_OFF_GCSR, 1'b1, 32'h1003);
    wait_idle;
    `CHK(d[13:8], 6'h01);
    `CHK(far.mem[164], 32'hc0de0002);
    bus(`LLD_OFF_GCSR, 1'b1, 32'h3f00);
    // 64-byte direct run stopped early, then restarted to the end
    bus(`LLD_OFF_SRC, 1'b1, 32'h80);
    bus(`LLD_OFF_DST, 1'b1, 32'hc0);
    bus(`LLD_OFF_TCR, 1'b1, {4'h0, 2'h2, 2'h1, 24'd64});
    bus(`LLD_OFF_GCSR, 1'b1, 32'h1);
    bus(`LLD_OFF_GCSR, 1'b1, 32'h4);
    wait_idle;
    `CHK(d[13:8], 6'h20);
    bus(`LLD_OFF_TCR, 1'b0, 32'h0);
    `CHK(d[23:0] != 24'd0 && d[23:0] < 24'd64, 1'b1);
    bus(`LLD_OFF_GCSR, 1'b1, 32'h3f00);
    bus(`LLD_OFF_GCSR, 1'b1, 32'h1);
    wait_idle;
    `CHK(d[13:8], 6'h01);
    for (c = 0; c < 16; c = c + 1) `CHK(far.mem[176 + c], 32'hc0de0020 + c);
    bus(`LLD_OFF_GCSR, 1'b1, 32'h3f00);
    // packet fetch faults of every kind on every port; processor bus has no target abort
    slow <= 1'b0;
    for (p = 0; p < 3; p = p + 1)
      for (c = 1; c < 4; c = c + 1)
        if (!(p == 2 && c == 2)) begin
          fault_port <= p[1:0];
          fault_code <= c[1:0];
          bus(`LLD_OFF_SRC, 1'b1, 32'h700 + p * 4 + c);
          bus(`LLD_OFF_ATTR, 1'b1, p);
          bus(`LLD_OFF_GCSR, 1'b1, 32'h3);
          wait_idle;
          `CHK(d[13:8], 6'h02 << p);
          bus(`LLD_OFF_SRC, 1'b0, 32'h0);
          `CHK(d, 32'h700 + p * 4 + c);
          fault_code <= 2'h0;
          bus(`LLD_OFF_GCSR, 1'b1, 32'h3f00);
        end
    // direct run faulted on the source (second pci) then on the destination (processor bus)
    for (p = 1; p < 3; p = p + 1) begin
      fault_port <= p[1:0];
      fault_code <= 2'h3;
      bus(`LLD_OFF_TCR, 1'b1, {4'h0, 2'h2, 2'h1, 24'd8});
      bus(`LLD_OFF_GCSR, 1'b1, 32'h1);
      wait_idle;
      `CHK(d[13:8], 6'h02 << p);
      bus(`LLD_OFF_TCR, 1'b0, 32'h0);
      `CHK(d[23:0], 24'd8);
      fault_code <= 2'h0;
      bus(`LLD_OFF_GCSR, 1'b1, 32'h3f00);
    end
    end_sim;
  end
endmodule
